// ===== hw/isf_status.sv
`timescale 1ns/1ps
module isf_status
    import isf_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [isf_pkg::ISF_ADDR_W-1:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SCL_OE_N,
    output logic SDA_OE_N,
    output logic TX_BUSY
);
    import isf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    logic [1:0] scl_s_r, sda_s_r;
    logic scl_d_r, sda_d_r;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], SCL_IN};
            sda_s_r <= {sda_s_r[0], SDA_IN};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end
    wire scl = scl_s_r[1];
    wire sda = sda_s_r[1];
    wire scl_rise = scl && !scl_d_r;
    wire scl_fall = !scl && scl_d_r;
    wire start_ev = scl && scl_d_r && !sda && sda_d_r;
    wire stop_ev = scl && scl_d_r && sda && !sda_d_r;

    ////////////////////////////////////////////////////////////////////////
    // slave receiver: byte framing, ack, address phases
    typedef enum logic [2:0] {ISF_IDLE, ISF_ADR1, ISF_ADR2, ISF_DATA, ISF_IGN} isf_state_t;
    isf_state_t st_r;
    logic [7:0] shift_r;
    logic [3:0] bit_r;
    logic ack_r, sda_oe_n_r, ten_r;
    logic [15:0] ctrl_r;
    logic [7:0] rx_r, tx_r;
    logic rbf_r, tbf_r, wcol_r, rov_r, data_r, stop_r, ten_bit_addr_matched_r;

    function automatic logic hi_match(input logic [7:0] b, input logic [9:0] own);
        hi_match = (b[7:3] == 5'h1E) && (b[2:1] == own[9:8]);
    endfunction

    wire byte_done = scl_rise && (bit_r == ISF_BITS_PER_BYTE - 4'h1);
    wire [7:0] byte_in = {shift_r[6:0], sda};
    wire ten_mode = ctrl_r[ISF_C_ADDR10];
    wire [9:0] own = ctrl_r[9:0];
    wire m7 = !ten_mode && (byte_in[7:1] == own[6:0]);
    wire m1 = ten_mode && hi_match(byte_in, own);
    wire m2 = (byte_in == own[7:0]);
    wire got_data = byte_done && (st_r == ISF_DATA);
    wire addr_hit = byte_done && ((st_r == ISF_ADR1 && m7) || (st_r == ISF_ADR2 && m2));

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_r <= ISF_IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            ack_r <= 1'b0;
        end else if (start_ev) begin
            st_r <= ISF_ADR1;
            bit_r <= 4'h0;
        end else if (stop_ev) begin
            st_r <= ISF_IDLE;
        end else if (scl_rise && st_r != ISF_IDLE && st_r != ISF_IGN) begin
            if (bit_r == ISF_BITS_PER_BYTE) begin
                bit_r <= 4'h0;
            end else begin
                shift_r <= byte_in;
                bit_r <= bit_r + 4'h1;
            end
            if (byte_done) begin
                case (st_r)
                    ISF_ADR1: st_r <= m7 ? ISF_DATA : (m1 ? ISF_ADR2 : ISF_IGN);
                    ISF_ADR2: st_r <= m2 ? ISF_DATA : ISF_IGN;
                    default: st_r <= st_r;
                endcase
                ack_r <= (st_r == ISF_DATA) || m7 || m1 || (st_r == ISF_ADR2 && m2);
            end
        end else if (scl_fall && bit_r == 4'h0) begin
            ack_r <= 1'b0;
        end
    end

    // ack driven low during the ninth clock; scl is never stretched
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sda_oe_n_r <= 1'b1;
        end else if (scl_fall) begin
            sda_oe_n_r <= !(ack_r && bit_r == ISF_BITS_PER_BYTE);
        end else if (start_ev || stop_ev) begin
            sda_oe_n_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags
    wire wr_st = WR && ADDR == ISF_OFS_STATUS;
    wire wr_tx = WR && ADDR == ISF_OFS_TX;
    wire rd_rx = RD && ADDR == ISF_OFS_RX;
    wire busy = (st_r != ISF_IDLE) || tbf_r;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_r <= 16'h0000;
            ctrl_r[9:0] <= ISF_OWN_ADDR_RST;
        end else if (WR && ADDR == ISF_OFS_CTRL) begin
            ctrl_r <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tx_r <= 8'h00;
            tbf_r <= 1'b0;
        end else if (wr_tx && !busy) begin
            tx_r <= WDATA[7:0];
            tbf_r <= 1'b1;
        end else if (start_ev) begin
            tbf_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wcol_r <= 1'b0;
        end else if (wr_tx && busy) begin
            wcol_r <= 1'b1;
        end else if (wr_st && !WDATA[ISF_B_WCOL]) begin
            wcol_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rov_r <= 1'b0;
            rbf_r <= 1'b0;
            rx_r <= 8'h00;
        end else begin
            if (got_data && rbf_r) begin
                rov_r <= 1'b1;
            end else if (wr_st && !WDATA[ISF_B_ROV]) begin
                rov_r <= 1'b0;
            end
            if (got_data && !rbf_r) begin
                rx_r <= byte_in;
                rbf_r <= 1'b1;
            end else if (rd_rx) begin
                rbf_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            data_r <= 1'b0;
            stop_r <= 1'b0;
            ten_bit_addr_matched_r <= 1'b0;
        end else begin
            if (addr_hit) begin
                data_r <= 1'b0;
            end else if (got_data) begin
                data_r <= 1'b1;
            end
            if (stop_ev) begin
                stop_r <= 1'b1;
            end else if (start_ev) begin
                stop_r <= 1'b0;
            end
            if (stop_ev) begin
                ten_bit_addr_matched_r <= 1'b0;
            end else if (byte_done && st_r == ISF_ADR2 && m2) begin
                ten_bit_addr_matched_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data one cycle after the strobe
    logic [15:0] status;
    always_comb begin
        status = ISF_STATUS_RST;
        status[ISF_B_ADDR10] = ten_bit_addr_matched_r;
        status[ISF_B_WCOL] = wcol_r;
        status[ISF_B_ROV] = rov_r;
        status[ISF_B_DATA] = data_r;
        status[ISF_B_STOP] = stop_r;
        status[ISF_B_RBF] = rbf_r;
        status[ISF_B_TBF] = tbf_r;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            case (ADDR)
                ISF_OFS_STATUS: RDATA <= status;
                ISF_OFS_CTRL: RDATA <= ctrl_r;
                ISF_OFS_TX: RDATA <= {8'h00, tx_r};
                ISF_OFS_RX: RDATA <= {8'h00, rx_r};
                default: RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            SCL_OE_N <= 1'b1;
            SDA_OE_N <= 1'b1;
            TX_BUSY <= 1'b0;
        end else begin
            SCL_OE_N <= 1'b1;
            SDA_OE_N <= sda_oe_n_r;
            TX_BUSY <= busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    wcol_set_a: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_tx && busy |=> wcol_r) else $error("collision not flagged");
    tx_drop_a: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_tx && busy |=> $stable(tx_r)) else $error("busy write took effect");
    wcol_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        wcol_r && !wr_st |=> wcol_r) else $error("collision cleared by hw");
    rov_set_a: assert property (@(posedge CLK) disable iff (!RST_N)
        got_data && rbf_r |=> rov_r && $stable(rx_r)) else $error("overflow missed");
    rov_sticky_a: assert property (@(posedge CLK) disable iff (!RST_N)
        rov_r && !wr_st |=> rov_r) else $error("overflow self cleared");
    da_addr_a: assert property (@(posedge CLK) disable iff (!RST_N)
        addr_hit |=> !data_r) else $error("address not marked");
    da_data_a: assert property (@(posedge CLK) disable iff (!RST_N)
        got_data |=> data_r) else $error("data not marked");
    stop_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
        stop_ev |=> stop_r) else $error("stop not flagged");
    start_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
        start_ev |=> !stop_r) else $error("start left stop set");
    ten_bit_addr_matched_clr_a: assert property (@(posedge CLK) disable iff (!RST_N)
        stop_ev |=> !ten_bit_addr_matched_r) else $error("ten-bit flag kept over stop");
    ten_bit_addr_matched_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(ten_bit_addr_matched_r) |-> $past(st_r) == ISF_ADR2) else $error("ten-bit flag spurious");
    w1_ign_a: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_st && WDATA[ISF_B_WCOL] && wcol_r |=> wcol_r) else $error("write one cleared");
    reset_zero_a: assert property (@(posedge CLK)
        !RST_N |=> status == ISF_STATUS_RST) else $error("flags not zero after reset");
    cov_ovf_c: cover property (@(posedge CLK) disable iff (!RST_N) got_data && rbf_r);
    cov_wcol_c: cover property (@(posedge CLK) disable iff (!RST_N) wr_tx && busy);
    cov_ten_c: cover property (@(posedge CLK) disable iff (!RST_N) $rose(ten_bit_addr_matched_r));
    cov_stop_c: cover property (@(posedge CLK) disable iff (!RST_N) stop_ev ##[1:400] start_ev);
endmodule // isf_status

// ===== hw/isf_pkg.sv
package isf_pkg;
    localparam logic [1:0] ISF_ADDR_W = 2'h2;
    // register offsets (word index on the plain port)
    localparam logic [1:0] ISF_OFS_STATUS = 2'h0;
    localparam logic [1:0] ISF_OFS_CTRL = 2'h1;
    localparam logic [1:0] ISF_OFS_TX = 2'h2;
    localparam logic [1:0] ISF_OFS_RX = 2'h3;
    // status word field positions
    localparam int ISF_B_ADDR10 = 8;
    localparam int ISF_B_WCOL = 7;
    localparam int ISF_B_ROV = 6;
    localparam int ISF_B_DATA = 5;
    localparam int ISF_B_STOP = 4;
    localparam int ISF_B_RBF = 1;
    localparam int ISF_B_TBF = 0;
    // control word fields
    localparam int ISF_C_ADDR10 = 15;
    localparam logic [15:0] ISF_STATUS_RST = 16'h0000;
    localparam logic [9:0] ISF_OWN_ADDR_RST = 10'h000;
    localparam logic [3:0] ISF_BITS_PER_BYTE = 4'h8;
endpackage

// ===== testbench/isf_i2c_master.sv
`timescale 1ns/1ps
// far-side bus master; sda is open drain with a pull-up, so a released line reads high
module isf_i2c_master (
    input wire logic SDA_OE_N,
    output logic SCL,
    output logic SDA,
    output logic ACKED
);
    logic sda_drv = 1'b1;
    assign SDA = sda_drv & SDA_OE_N;
    initial begin
        SCL = 1'b1;
        ACKED = 1'b0;
    end
    task automatic bit_out(input logic b);
        sda_drv = b;
        #40 SCL = 1'b1;
        #40 SCL = 1'b0;
    endtask
    // step off the clock edge so pin changes never race the sampling flops
    task automatic start();
        #2;
        sda_drv = 1'b1;
        #40 SCL = 1'b1;
        #40 sda_drv = 1'b0;
        #40 SCL = 1'b0;
    endtask
    task automatic stop();
        #2;
        sda_drv = 1'b0;
        #40 SCL = 1'b1;
        #40 sda_drv = 1'b1;
    endtask
    // msb first, then the ninth clock with sda released for the ack
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        sda_drv = 1'b1;
        #40 SCL = 1'b1;
        ACKED = ~SDA;
        #40 SCL = 1'b0;
    endtask
endmodule // isf_i2c_master

// ===== testbench/isf_status_tb.sv
`timescale 1ns/1ps
module isf_status_tb;
    import isf_pkg::*;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [ISF_ADDR_W-1:0] ADDR = 2'h0;
    logic [15:0] WDATA = 16'h0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [15:0] RDATA;
    logic SCL, SDA, SCL_OE_N, SDA_OE_N, TX_BUSY, ACKED;
    logic [15:0] st;
    int fails = 0;
    int cmp_count = 0;
    isf_status u_isf_status (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .SCL_IN(SCL), .SDA_IN(SDA), .SCL_OE_N(SCL_OE_N),
        .SDA_OE_N(SDA_OE_N), .TX_BUSY(TX_BUSY));
    isf_i2c_master u_isf_i2c_master (.SDA_OE_N(SDA_OE_N), .SCL(SCL), .SDA(SDA), .ACKED(ACKED));
    initial begin
        forever #4 CLK = ~CLK;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [1:0] a);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 st = RDATA;
    endtask
    task automatic chk(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %b", $time, got);
        end
    endtask
    // bus pins pass a two-flop sync before the flags move
    task automatic settle();
        repeat (8) @(posedge CLK);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic scen_reset();
        reg_rd(ISF_OFS_STATUS);
        chk(st === 16'h0000, 1'b1);
        chk(TX_BUSY, 1'b0);
        chk(SCL_OE_N, 1'b1);
    endtask
    task automatic scen_slave_rx();
        reg_wr(ISF_OFS_CTRL, 16'h002A);
        u_isf_i2c_master.start();
        u_isf_i2c_master.send(8'h54);
        chk(ACKED, 1'b1);
        settle();
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_DATA], 1'b0);
        chk(st[ISF_B_STOP], 1'b0);
        reg_wr(ISF_OFS_TX, 16'h0011);
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_WCOL], 1'b1);
        chk(st[ISF_B_TBF], 1'b0);
        u_isf_i2c_master.send(8'hA5);
        settle();
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_DATA], 1'b1);
        chk(st[ISF_B_ROV], 1'b0);
        u_isf_i2c_master.send(8'h3C);
        settle();
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_ROV], 1'b1);
        reg_rd(ISF_OFS_RX);
        chk(st[7:0] === 8'hA5, 1'b1);
        u_isf_i2c_master.stop();
        settle();
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_STOP], 1'b1);
        chk(st[ISF_B_WCOL], 1'b1);
        chk(st[ISF_B_ADDR10], 1'b0);
        reg_wr(ISF_OFS_STATUS, 16'h00C0);
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_ROV] & st[ISF_B_WCOL], 1'b1);
        reg_wr(ISF_OFS_STATUS, 16'h0000);
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_ROV] | st[ISF_B_WCOL], 1'b0);
    endtask
    // a full transmit buffer also makes the port busy
    task automatic scen_tx_full();
        reg_wr(ISF_OFS_TX, 16'h0055);
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_TBF] & TX_BUSY, 1'b1);
        reg_wr(ISF_OFS_TX, 16'h0066);
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_WCOL], 1'b1);
        reg_rd(ISF_OFS_TX);
        chk(st === 16'h0055, 1'b1);
        reg_wr(ISF_OFS_STATUS, 16'h0000);
    endtask
    task automatic scen_ten_bit();
        reg_wr(ISF_OFS_CTRL, 16'h82A5);
        u_isf_i2c_master.start();
        u_isf_i2c_master.send(8'hF4);
        u_isf_i2c_master.send(8'hA5);
        settle();
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_ADDR10], 1'b1);
        chk(st[ISF_B_STOP], 1'b0);
        chk(st[ISF_B_DATA], 1'b0);
        u_isf_i2c_master.start();
        settle();
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_STOP], 1'b0);
        chk(st[ISF_B_ADDR10], 1'b1);
        u_isf_i2c_master.stop();
        settle();
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_ADDR10], 1'b0);
        chk(st[ISF_B_STOP], 1'b1);
        // upper address bits differ: the port must ignore the frame
        u_isf_i2c_master.start();
        u_isf_i2c_master.send(8'hF6);
        chk(ACKED, 1'b0);
        u_isf_i2c_master.stop();
        settle();
        reg_rd(ISF_OFS_STATUS);
        chk(st[ISF_B_ADDR10], 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        scen_reset();
        scen_slave_rx();
        scen_tx_full();
        scen_ten_bit();
        report_and_stop();
    end
    initial begin
        repeat (50000) @(posedge CLK);
        fails++;
        report_and_stop();
    end
endmodule // isf_status_tb
